/* File: tlip_pkg.sv */
// Purpose: Shared constants and carriers for the two-level interrupt priority controller
// Assumes: One instruction-cycle clock, sources presented as a flat vector
// Notes:   Source count is fixed; external pin sources are marked by a mask constant
package tlip_pkg;

    localparam int          NUM_SRC          = 8;
    localparam logic [20:0] HIGH_VECTOR_ADDR = 21'h00008;
    localparam logic [20:0] LOW_VECTOR_ADDR  = 21'h00018;
    localparam logic [20:0] PC_RESET_VALUE   = 21'h00000;
    localparam int          PRIO_ON_BIT      = 7;
    localparam int          GIE_HIGH_BIT     = 7;
    localparam int          GIE_LOW_BIT      = 6;
    localparam logic [7:0]  CTRL_RESET_VALUE = 8'h00;
    localparam logic [7:0]  RESET_CONTROL_REG_RESET_VALUE = 8'h00;
    // External pin and port-change sources: bits 0..4 here
    localparam logic [7:0]  EXT_SRC_MASK     = 8'h1F;
    // Sources counted as peripherals for the compatibility-mode gate
    localparam logic [7:0]  PERIPH_SRC_MASK  = 8'hE0;
    // Entry latency for pin events, in instruction cycles (3..4 allowed)
    localparam logic [2:0]  EXT_LATENCY_CYC  = 3'h3;
    localparam logic [1:0]  LVL_NONE         = 2'h0;

    typedef enum logic [1:0] {
        TLIP_IDLE  = 2'b00,
        TLIP_DELAY = 2'b01,
        TLIP_ENTER = 2'b10
    } tlip_state_e;

    typedef struct packed {
        logic [NUM_SRC-1:0] flag;
        logic [NUM_SRC-1:0] enable;
        logic [NUM_SRC-1:0] prio_high;
    } tlip_src_s;

    typedef struct packed {
        logic        valid;
        logic        high;
        logic [20:0] vector;
        logic [20:0] ret_addr;
    } tlip_entry_s;

endpackage : tlip_pkg

/* File: tlip_ctrl.sv */
// Purpose: Interrupt priority controller: flags, enables, priority, vectoring, nesting
// Assumes: Clock is the core instruction clock; event inputs come from same-clock logic
// Notes:   Core writes control bytes with a write strobe; entry is reported as one pulse
module tlip_ctrl (
    // Clock and reset
    input  wire logic                          sys_clk_i,
    input  wire logic                          reset_n_i,
    // Source events, one-cycle pulses from peripherals and pin logic
    input  wire logic [tlip_pkg::NUM_SRC-1:0]  src_event_i,
    // Software writes from the core
    input  wire logic                          ctrl_wr_i,
    input  wire logic [7:0]                    ctrl_wdata_i,
    input  wire logic                          reset_control_reg_wr_i,
    input  wire logic [7:0]                    reset_control_reg_wdata_i,
    input  wire logic                          flag_wr_i,
    input  wire logic [tlip_pkg::NUM_SRC-1:0]  flag_wdata_i,
    input  wire logic                          enable_wr_i,
    input  wire logic [tlip_pkg::NUM_SRC-1:0]  enable_wdata_i,
    input  wire logic                          prio_wr_i,
    input  wire logic [tlip_pkg::NUM_SRC-1:0]  prio_wdata_i,
    // Core fetch interface
    input  wire logic [20:0]                   core_pc_i,
    input  wire logic                          return_from_irq_instr_i,
    // Register views
    output logic [7:0]                         irq_control_reg_o,
    output logic [7:0]                         reset_control_reg_o,
    output tlip_pkg::tlip_src_s                src_state_o,
    // Entry towards the core
    output tlip_pkg::tlip_entry_s              entry_o,
    output logic                               in_high_isr_o,
    output logic                               in_low_isr_o
);

    typedef struct packed {
        tlip_pkg::tlip_state_e st;
        logic [2:0]            lat_cnt;
        logic                  pend_high;
        logic [7:0]            ctrl;
        logic [7:0]            reset_control_reg;
        tlip_pkg::tlip_src_s   src;
        tlip_pkg::tlip_entry_s entry;
        logic                  in_high;
        logic                  in_low;
    } tlip_regs_s;

    tlip_regs_s state_reg;
    tlip_regs_s state_next;

    // Any qualified source among those selected by the mask
    function automatic logic any_req(input logic [tlip_pkg::NUM_SRC-1:0] f,
                                     input logic [tlip_pkg::NUM_SRC-1:0] e,
                                     input logic [tlip_pkg::NUM_SRC-1:0] m);
        any_req = |(f & e & m);
    endfunction : any_req

    logic prio_on;
    logic gie_high;
    logic gie_low;
    logic req_high;
    logic req_low;
    logic req_any;

    always_comb begin
        prio_on  = state_reg.reset_control_reg[tlip_pkg::PRIO_ON_BIT];
        gie_high = state_reg.ctrl[tlip_pkg::GIE_HIGH_BIT];
        gie_low  = state_reg.ctrl[tlip_pkg::GIE_LOW_BIT];
        if (prio_on) begin
            req_high = gie_high &&
                       any_req(state_reg.src.flag, state_reg.src.enable,
                               state_reg.src.prio_high);
            // Low level blocked while a high routine runs
            req_low  = gie_low && !state_reg.in_high &&
                       any_req(state_reg.src.flag, state_reg.src.enable,
                               ~state_reg.src.prio_high);
        end else begin
            // Priority bits take no part here
            req_high = gie_high &&
                       (any_req(state_reg.src.flag, state_reg.src.enable,
                                ~tlip_pkg::PERIPH_SRC_MASK) ||
                        (gie_low && any_req(state_reg.src.flag, state_reg.src.enable,
                                            tlip_pkg::PERIPH_SRC_MASK)));
            req_low  = 1'b0;
        end
        req_any = req_high || req_low;
    end

    always_comb begin
        state_next             = state_reg;
        state_next.entry.valid = 1'b0;

        // Hardware set wins over a software clear in the same cycle
        if (flag_wr_i) begin
            state_next.src.flag = flag_wdata_i;
        end
        state_next.src.flag = state_next.src.flag | src_event_i;
        if (enable_wr_i) begin
            state_next.src.enable = enable_wdata_i;
        end
        if (prio_wr_i) begin
            state_next.src.prio_high = prio_wdata_i;
        end
        if (reset_control_reg_wr_i) begin
            state_next.reset_control_reg = reset_control_reg_wdata_i;
        end
        if (ctrl_wr_i) begin
            state_next.ctrl = ctrl_wdata_i;
        end

        // Return re-arms the level that was left; high unwinds before low
        if (return_from_irq_instr_i) begin
            if (!prio_on) begin
                state_next.ctrl[tlip_pkg::GIE_HIGH_BIT] = 1'b1;
                state_next.in_high = 1'b0;
            end else if (state_reg.in_high) begin
                state_next.ctrl[tlip_pkg::GIE_HIGH_BIT] = 1'b1;
                state_next.in_high = 1'b0;
            end else if (state_reg.in_low) begin
                state_next.ctrl[tlip_pkg::GIE_LOW_BIT] = 1'b1;
                state_next.in_low = 1'b0;
            end
        end

        unique case (state_reg.st)
            tlip_pkg::TLIP_IDLE: begin
                if (req_any) begin
                    // High chosen first when both qualify
                    state_next.pend_high = req_high;
                    // Fixed latency for all sources keeps pin latency independent of
                    // the interrupted instruction length
                    state_next.lat_cnt = tlip_pkg::EXT_LATENCY_CYC - 3'h2;
                    state_next.st      = tlip_pkg::TLIP_DELAY;
                end
            end
            tlip_pkg::TLIP_DELAY: begin
                if (state_reg.lat_cnt == 3'h0) begin
                    state_next.st = tlip_pkg::TLIP_ENTER;
                end else begin
                    state_next.lat_cnt = state_reg.lat_cnt - 3'h1;
                end
            end
            tlip_pkg::TLIP_ENTER: begin
                state_next.st = tlip_pkg::TLIP_IDLE;
                // Request may have vanished if software disabled it meanwhile
                if (req_high || (req_low && !state_reg.pend_high)) begin
                    state_next.entry.valid    = 1'b1;
                    state_next.entry.ret_addr = core_pc_i;
                    state_next.entry.high     = req_high;
                    if (req_high) begin
                        state_next.entry.vector = tlip_pkg::HIGH_VECTOR_ADDR;
                        state_next.ctrl[tlip_pkg::GIE_HIGH_BIT] = 1'b0;
                        state_next.in_high = 1'b1;
                    end else begin
                        state_next.entry.vector = tlip_pkg::LOW_VECTOR_ADDR;
                        state_next.ctrl[tlip_pkg::GIE_LOW_BIT] = 1'b0;
                        state_next.in_low = 1'b1;
                    end
                end
            end
            default: begin
                state_next.st = tlip_pkg::TLIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg.st        <= tlip_pkg::TLIP_IDLE;
            state_reg.lat_cnt   <= 3'h0;
            state_reg.pend_high <= 1'b0;
            state_reg.ctrl      <= tlip_pkg::CTRL_RESET_VALUE;
            state_reg.reset_control_reg      <= tlip_pkg::RESET_CONTROL_REG_RESET_VALUE;
            state_reg.src       <= '0;
            state_reg.entry     <= '0;
            state_reg.in_high   <= 1'b0;
            state_reg.in_low    <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        irq_control_reg_o   = state_reg.ctrl;
        reset_control_reg_o = state_reg.reset_control_reg;
        src_state_o         = state_reg.src;
        entry_o             = state_reg.entry;
        in_high_isr_o       = state_reg.in_high;
        in_low_isr_o        = state_reg.in_low;
    end

endmodule : tlip_ctrl

/* File: tlip_ctrl_sva.sv */
// Purpose: Port-level checks of the interrupt priority controller
// Assumes: Single clock domain, async active-low reset
// Notes:   Entry outputs are sampled in the cycle that valid is high
module tlip_ctrl_sva (
    // Clock and reset
    input wire logic                  sys_clk_i,
    input wire logic                  reset_n_i,
    // Stimulus side
    input wire logic [7:0]            src_event_i,
    input wire logic                  return_from_irq_instr_i,
    // Observed state
    input wire logic [7:0]            irq_control_reg_o,
    input wire logic [7:0]            reset_control_reg_o,
    input wire tlip_pkg::tlip_src_s   src_state_o,
    input wire tlip_pkg::tlip_entry_s entry_o,
    input wire logic                  in_high_isr_o,
    input wire logic                  in_low_isr_o
);
    localparam logic [20:0] HV = tlip_pkg::HIGH_VECTOR_ADDR;
    localparam logic [20:0] LV = tlip_pkg::LOW_VECTOR_ADDR;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_vh; entry_o.valid && entry_o.high |-> entry_o.vector == HV; endproperty
    a_vh: assert property (p_vh) else $error("high vector wrong");
    property p_vl; entry_o.valid && !entry_o.high |-> entry_o.vector == LV; endproperty
    a_vl: assert property (p_vl) else $error("low vector wrong");
    property p_cm; entry_o.valid && !reset_control_reg_o[7] |-> entry_o.vector == HV; endproperty
    a_cm: assert property (p_cm) else $error("single-level vector wrong");
    property p_ch; entry_o.valid && entry_o.high |-> !irq_control_reg_o[7] && in_high_isr_o;
    endproperty
    a_ch: assert property (p_ch) else $error("high entry left enable set");
    property p_cl; entry_o.valid && !entry_o.high |-> !irq_control_reg_o[6] && in_low_isr_o;
    endproperty
    a_cl: assert property (p_cl) else $error("low entry left enable set");
    property p_nl; entry_o.valid && !entry_o.high |-> !$past(in_high_isr_o); endproperty
    a_nl: assert property (p_nl) else $error("low entry during high routine");
    property p_fl; |src_event_i |=> (src_state_o.flag & $past(src_event_i)) == $past(src_event_i);
    endproperty
    a_fl: assert property (p_fl) else $error("event did not set flag");
    property p_rh; return_from_irq_instr_i && in_high_isr_o |=> irq_control_reg_o[7] && !in_high_isr_o;
    endproperty
    a_rh: assert property (p_rh) else $error("return did not re-enable");
endmodule : tlip_ctrl_sva

bind tlip_ctrl tlip_ctrl_sva u_sva (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .src_event_i(src_event_i), .return_from_irq_instr_i(return_from_irq_instr_i),
    .irq_control_reg_o(irq_control_reg_o), .reset_control_reg_o(reset_control_reg_o),
    .src_state_o(src_state_o), .entry_o(entry_o), .in_high_isr_o(in_high_isr_o),
    .in_low_isr_o(in_low_isr_o));

/* File: tlip_core_model.sv */
// Purpose: Behavioural core fetch and return stack facing the controller
// Assumes: Two-byte instruction words, return issued on bench command
// Notes:   Return on an empty stack is ignored rather than flagged
module tlip_core_model (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_n_i,
    input  wire tlip_pkg::tlip_entry_s entry_i,
    input  wire logic                  ret_cmd_i,
    output logic [20:0]                pc_o,
    output logic                       ret_o
);
    logic [20:0] stack_q [$];
    assign ret_o = ret_cmd_i;
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_o <= 21'h00000;
            stack_q.delete();
        end else if (entry_i.valid) begin
            stack_q.push_back(entry_i.ret_addr);
            pc_o <= entry_i.vector;
        end else if (ret_cmd_i && stack_q.size() > 0) begin
            pc_o <= stack_q.pop_back();
        end else begin
            pc_o <= pc_o + 21'h00002;
        end
    end
endmodule : tlip_core_model

/* File: tlip_ctrl_tb.sv */
// Purpose: Directed scenarios for the interrupt priority controller
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   One shared write-data bus feeds every control write port
module tlip_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [20:0] HV = tlip_pkg::HIGH_VECTOR_ADDR;
    localparam logic [20:0] LV = tlip_pkg::LOW_VECTOR_ADDR;
    logic sys_clk = 1'b0, rst_n = 1'b0, ret_cmd = 1'b0, ret;
    logic [4:0] wr_sel = 5'h00;
    logic [7:0] src = 8'h00, wdata = 8'h00, ctrl_q, reset_control_reg_q;
    logic [20:0] pc;
    logic in_hi, in_lo;
    tlip_pkg::tlip_src_s st;
    tlip_pkg::tlip_entry_s ent;
    int n_fail = 0, num_checks = 0, n = 0;
    always #5 sys_clk = ~sys_clk;
    tlip_ctrl DUT (.sys_clk_i(sys_clk), .reset_n_i(rst_n), .src_event_i(src),
        .ctrl_wr_i(wr_sel[4]), .ctrl_wdata_i(wdata), .reset_control_reg_wr_i(wr_sel[3]), .reset_control_reg_wdata_i(wdata),
        .flag_wr_i(wr_sel[2]), .flag_wdata_i(wdata), .enable_wr_i(wr_sel[1]),
        .enable_wdata_i(wdata), .prio_wr_i(wr_sel[0]), .prio_wdata_i(wdata), .core_pc_i(pc),
        .return_from_irq_instr_i(ret), .irq_control_reg_o(ctrl_q), .reset_control_reg_o(reset_control_reg_q),
        .src_state_o(st), .entry_o(ent), .in_high_isr_o(in_hi), .in_low_isr_o(in_lo));
    tlip_core_model u_core (.sys_clk_i(sys_clk), .reset_n_i(rst_n), .entry_i(ent),
        .ret_cmd_i(ret_cmd), .pc_o(pc), .ret_o(ret));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    // Plain single-register stores only
    task automatic wr(input int k, input logic [7:0] d);
        wr_sel = 5'h10 >> k;
        wdata = d;
        tick();
        wr_sel = 5'h00;
        n = 0;
    endtask : wr
    task automatic ev(input logic [7:0] m);
        src = m;
        tick();
        src = 8'h00;
        n = 0;
    endtask : ev
    task automatic take(input logic [20:0] v);
        while (ent.valid !== 1'b1 && n < 12) begin
            tick();
            n++;
        end
        chk(ent.valid, 1'b1);
        chk(ent.vector, v);
        tick();
        chk(pc, v);
    endtask : take
    task automatic no_entry(input int c);
        repeat (c) begin
            tick();
            chk(ent.valid, 1'b0);
        end
    endtask : no_entry
    task automatic rti();
        ret_cmd = 1'b1;
        tick();
        ret_cmd = 1'b0;
        tick();
        n = 0;
    endtask : rti
    task automatic t_reset();
        chk(reset_control_reg_q, 8'h00);
        chk(ctrl_q, 8'h00);
        chk(st, 24'h000000);
    endtask : t_reset
    task automatic t_compat();
        wr(3, 8'h21);
        wr(4, 8'h00);
        wr(0, 8'h80);
        ev(8'h01);
        take(HV);
        chk(n, 4);
        tick();
        chk(ctrl_q, 8'h00);
        wr(2, 8'h00);
        rti();
        chk(ctrl_q, 8'h80);
    endtask : t_compat
    task automatic t_periph();
        ev(8'hA0);
        no_entry(6);
        chk(st.flag, 8'hA0);
        wr(0, 8'hC0);
        take(HV);
        tick();
        chk(ctrl_q, 8'h40);
        wr(2, 8'h00);
        rti();
    endtask : t_periph
    task automatic t_prio();
        wr(1, 8'h80);
        chk(reset_control_reg_q, 8'h80);
        wr(3, 8'h06);
        wr(4, 8'h02);
        ev(8'h06);
        take(HV);
        wr(2, 8'h04);
        no_entry(6);
        rti();
        take(LV);
        tick();
        chk(ctrl_q, 8'h80);
        ev(8'h02);
        take(HV);
        chk(in_lo, 1'b1);
        wr(2, 8'h00);
        rti();
        rti();
        chk(ctrl_q, 8'hC0);
    endtask : t_prio
    task automatic t_gate();
        wr(0, 8'h80);
        ev(8'h04);
        no_entry(5);
        wr(2, 8'h00);
        wr(0, 8'h40);
        ev(8'h02);
        no_entry(5);
    endtask : t_gate
    task automatic summarize();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_compat();
        t_periph();
        t_prio();
        t_gate();
        summarize();
    end
    initial begin
        #100000;
        n_fail++;
        summarize();
    end
endmodule : tlip_ctrl_tb
